// ---- dv/msr_bench.sv ----
// Self-checking bench for the mode, input and sequencer registers
`timescale 1ns/10ps
`include "msr_consts.svh"
module mode_input_sequencer_regs_bench;
  import msr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  msr_bus_req_t req_i = '0;
  logic fast_link_i = 1'b0;
  logic seq_done_i;
  logic [7:0] rd_data_o;
  logic cal_pulse_o;
  logic scan_launch_o;
  logic busy_o;
  msr_mode_t mode_o;
  msr_input_t input_arr_o;
  logic [1:0] scan_sel_o;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int fails = 0;
  int tests_run = 0;
  logic [2:0] code;

  // System clock, 10 ns period
  always #5 clk_sys_i = ~clk_sys_i;

  msr_regs i_msr_regs (.clk_sys_i, .rst_i, .ce_i, .req_i, .rd_data_o,
    .fast_link_i, .seq_done_i, .cal_pulse_o, .scan_launch_o, .busy_o,
    .mode_o, .input_arr_o, .scan_sel_o);
  msr_seq_model i_msr_seq_model (.clk_sys_i, .rst_i,
    .scan_launch_i(scan_launch_o), .seq_done_o(seq_done_i));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    req_i.wr = 1'b1;
    req_i.addr = a;
    req_i.wdata = d;
    @(negedge clk_sys_i);
    req_i.wr = 1'b0;
  endtask : wr

  // Expected byte is queued; status reads add the sampled link state
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    req_i.rd = 1'b1;
    req_i.addr = a;
    fast_link_i = 1'($urandom);
    exp_q.push_back(a == 8'h00 ? (e | {5'h00, fast_link_i, 2'h0}) : e);
    @(negedge clk_sys_i);
    req_i.rd = 1'b0;
  endtask : rd

  // Read data lands on the taking edge and is checked on the next falling edge
  always @(posedge clk_sys_i) rd_seen <= req_i.rd & ~rst_i & ce_i;
  always @(negedge clk_sys_i) begin
    if (rd_seen) begin
      check(rd_data_o, exp_q.pop_front());
    end
  end

  task automatic results;
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    void'($urandom(46975));
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
    // Reset values, write-only and unmapped places
    check(8'(scan_sel_o), 8'h03);
    rd(`MSR_ADDR_CHEN, 8'h03);
    rd(`MSR_ADDR_CAL, 8'h00);
    rd(`MSR_ADDR_START, 8'h00);
    rd(8'h7F, 8'h00);
    wr(`MSR_ADDR_STATUS, 8'hFF);
    rd(`MSR_ADDR_STATUS, 8'h00);
    // Every legal mode code, junk in the upper bits
    for (int c = 0; c < 8; c++) begin
      if (c == 2 || c == 3) continue;
      code = 3'(c);
      wr(`MSR_ADDR_MODE, {5'($urandom), code});
      repeat (2) @(negedge clk_sys_i);
      check(8'(mode_o), {4'h0, ~(code[2] & code[1]), code[2],
        code == 3'h6, code == 3'h7});
      rd(`MSR_ADDR_MODE, {5'h00, code});
      rd(`MSR_ADDR_STATUS, {6'h00,
        (code[2] & code[1]) ? {1'b1, code[0]} : 2'h0});
    end
    // Input arrangements and channel selections
    for (int v = 0; v < 4; v++) begin
      wr(`MSR_ADDR_INCFG, {6'($urandom), 2'(v)});
      wr(`MSR_ADDR_CHEN, {6'($urandom), 2'(v)});
      repeat (2) @(negedge clk_sys_i);
      check(8'(input_arr_o), (v == 3) ? 8'h00 : 8'(v));
      check(8'(scan_sel_o), 8'(v));
      rd(`MSR_ADDR_INCFG, 8'(v));
      rd(`MSR_ADDR_CHEN, 8'(v));
    end
    // Pulses only on a written one, then busy until done
    for (int k = 0; k < 2; k++) begin
      wr(`MSR_ADDR_CAL, k ? 8'h01 : 8'hFE);
      check(8'(cal_pulse_o), 8'(k));
      wr(`MSR_ADDR_START, k ? 8'h01 : 8'hFE);
      check(8'({cal_pulse_o, scan_launch_o, busy_o}),
        k ? 8'h03 : 8'h00);
      @(negedge clk_sys_i);
      check(8'({scan_launch_o, busy_o}), 8'(k));
      for (int i = 0; i < 40 && busy_o === 1'b1; i++) begin
        @(negedge clk_sys_i);
      end
      check(8'(busy_o), 8'h00);
    end
    // Clock enable low: writes are not taken, state is held
    @(negedge clk_sys_i);
    ce_i = 1'b0;
    wr(`MSR_ADDR_MODE, 8'h04);
    wr(`MSR_ADDR_CAL, 8'h01);
    check(8'({cal_pulse_o, busy_o}), 8'h00);
    repeat (2) @(negedge clk_sys_i);
    check(8'(mode_o), 8'h05);
    ce_i = 1'b1;
    rd(`MSR_ADDR_MODE, 8'h07);
    // Second reset in mid-run brings every field back
    wr(`MSR_ADDR_CHEN, 8'h00);
    @(negedge clk_sys_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    check(8'({mode_o, scan_sel_o}), 8'h23);
    rd(`MSR_ADDR_MODE, 8'h00);
    rd(`MSR_ADDR_CHEN, 8'h03);
    results();
  end
endmodule : mode_input_sequencer_regs_bench

// ---- dv/msr_seq_model.sv ----
// Behavioural sequencer that answers scan launches
`timescale 1ns/10ps
module msr_seq_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Handshake with the register bank
  input wire logic scan_launch_i,
  output logic seq_done_o
);
  int wait_cnt;

  // Scan lasts a random few cycles so busy must hold meanwhile
  initial begin
    seq_done_o = 1'b0;
    forever begin
      @(posedge clk_sys_i);
      if (scan_launch_i === 1'b1 && rst_i === 1'b0) begin
        wait_cnt = 3 + ($urandom % 8);
        repeat (wait_cnt) @(posedge clk_sys_i);
        seq_done_o <= 1'b1;
        @(posedge clk_sys_i);
        seq_done_o <= 1'b0;
      end
    end
  end
endmodule : msr_seq_model

// ---- logic/msr_consts.svh ----
// Address map, field positions, reset values and codes of the register bank
`ifndef MSR_CONSTS_SVH
`define MSR_CONSTS_SVH

// Register offsets on the serial register port
`define MSR_ADDR_STATUS 8'h00
`define MSR_ADDR_CAL 8'h15
`define MSR_ADDR_MODE 8'h1C
`define MSR_ADDR_START 8'h1E
`define MSR_ADDR_CHEN 8'h20
`define MSR_ADDR_INCFG 8'h24

// Field widths and positions
`define MSR_DATA_W 8
`define MSR_ADDR_W 8
`define MSR_MODE_W 3
`define MSR_INCFG_W 2
`define MSR_CHAN_N 2
`define MSR_TRIG_BIT 0
`define MSR_LAUNCH_BIT 0
`define MSR_FAST_BIT 2
`define MSR_AUTOSEQ_BIT 2
`define MSR_CUR_W 2

// Reset values
`define MSR_MODE_RST 3'h0
`define MSR_CHEN_RST 1'h1
`define MSR_INCFG_RST 2'h0
`define MSR_BYTE_ZERO 8'h00

// Mode select codes and input arrangement codes
`define MSR_MODE_AUTONOMOUS 3'h6
`define MSR_MODE_PRECISION 3'h7
`define MSR_IN_RGS_CODE 2'h1
`define MSR_IN_PDIFF_CODE 2'h2

// Current mode report codes
`define MSR_CUR_MANUAL 2'h0
`define MSR_CUR_AUTONOMOUS 2'h2
`define MSR_CUR_PRECISION 2'h3
`define MSR_CUR_UNUSED 2'h1

`endif

// ---- logic/msr_field_reg.sv ----
// Writable register field with reset value and clock enable
`timescale 1ns/10ps
module msr_field_reg #(
  parameter int W = 2,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Write port
  input wire logic we_i,
  input wire logic [W-1:0] d_i,
  // Stored value
  output logic [W-1:0] q_o
);

  logic [W-1:0] next_q;

  // Load on write, hold otherwise
  always_comb begin
    next_q = q_o;
    if (we_i) begin
      next_q = d_i;
    end
  end

  // Register with synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q_o <= RST;
    end else if (ce_i) begin
      q_o <= next_q;
    end
  end

endmodule : msr_field_reg

// ---- logic/msr_pkg.sv ----
// Types shared by the mode, input and sequencer register bank
`include "msr_consts.svh"
package msr_pkg;

  // One access from the serial interface engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`MSR_ADDR_W-1:0] addr;
    logic [`MSR_DATA_W-1:0] wdata;
  } msr_bus_req_t;

  // Decoded operating mode towards the sequencer
  typedef struct packed {
    logic manual;
    logic auto_seq;
    logic autonomous;
    logic high_precision;
  } msr_mode_t;

  // Analog input arrangement towards the multiplexer
  typedef enum logic [1:0] {
    MSR_IN_DUAL_SE,
    MSR_IN_SINGLE_RGS,
    MSR_IN_PSEUDO_DIFF
  } msr_input_t;

endpackage : msr_pkg

// ---- logic/msr_regs.sv ----
// Mode, input configuration and sequencer control register bank
`timescale 1ns/10ps
`include "msr_consts.svh"

// Behaviour
// - calibration bit one launches offset calibration
// - mode register upper bits read zero, ignored
// - mode field decodes manual, autonomous, precision
// - status register is read only
// - status bit two shows fast link
// - current mode reports 00, 10, 11 only
// - input field decodes channel arrangement
// - enable bit one selects second channel
// - enable bit zero selects first channel
// - channel enable resets to both channels
// - write of start bit one to start register begins scan
// - start bit raises busy, launches conversion
module msr_regs (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port from the serial interface engine
  input wire msr_pkg::msr_bus_req_t req_i,
  output logic [`MSR_DATA_W-1:0] rd_data_o,
  input wire logic fast_link_i,
  // Sequencer feedback
  input wire logic seq_done_i,
  // Control towards calibration, sequencer and multiplexer
  output logic cal_pulse_o,
  output logic scan_launch_o,
  output logic busy_o,
  output msr_pkg::msr_mode_t mode_o,
  output msr_pkg::msr_input_t input_arr_o,
  output logic [`MSR_CHAN_N-1:0] scan_sel_o
);
  import msr_pkg::*;

  logic hit_cal;
  logic hit_mode;
  logic hit_start;
  logic hit_chen;
  logic hit_incfg;
  logic [`MSR_MODE_W-1:0] mode_select_field;
  logic [`MSR_INCFG_W-1:0] input_arrangement;
  logic [`MSR_CUR_W-1:0] current_mode_field;
  logic next_cal;
  logic next_launch;
  logic next_busy;
  logic [`MSR_DATA_W-1:0] next_rd_data;
  msr_mode_t next_mode;
  msr_input_t next_input;

  // Address decode of writes
  assign hit_cal = req_i.wr && (req_i.addr == `MSR_ADDR_CAL);
  assign hit_mode = req_i.wr && (req_i.addr == `MSR_ADDR_MODE);
  assign hit_start = req_i.wr && (req_i.addr == `MSR_ADDR_START);
  assign hit_chen = req_i.wr && (req_i.addr == `MSR_ADDR_CHEN);
  assign hit_incfg = req_i.wr && (req_i.addr == `MSR_ADDR_INCFG);

  // Only the low three bits are stored, so upper bits stay zero
  msr_field_reg #(
    .W(`MSR_MODE_W),
    .RST(`MSR_MODE_RST)
  ) u_mode (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(hit_mode),
    .d_i(req_i.wdata[`MSR_MODE_W-1:0]),
    .q_o(mode_select_field)
  );

  // Input arrangement field
  msr_field_reg #(
    .W(`MSR_INCFG_W),
    .RST(`MSR_INCFG_RST)
  ) u_incfg (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(hit_incfg),
    .d_i(req_i.wdata[`MSR_INCFG_W-1:0]),
    .q_o(input_arrangement)
  );

  // One enable bit per channel, both set after reset
  for (genvar ch = 0; ch < `MSR_CHAN_N; ch++) begin : g_chan
    msr_field_reg #(
      .W(1),
      .RST(`MSR_CHEN_RST)
    ) u_sel (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .we_i(hit_chen),
      .d_i(req_i.wdata[ch]),
      .q_o(scan_sel_o[ch])
    );
  end

  // Mode decode; reserved codes fall back to manual as a safe choice
  always_comb begin
    next_mode.auto_seq = mode_select_field[`MSR_AUTOSEQ_BIT];
    next_mode.autonomous = (mode_select_field == `MSR_MODE_AUTONOMOUS);
    next_mode.high_precision = (mode_select_field == `MSR_MODE_PRECISION);
    next_mode.manual = !(next_mode.autonomous || next_mode.high_precision);
    case (input_arrangement)
      `MSR_IN_RGS_CODE: next_input = MSR_IN_SINGLE_RGS;
      `MSR_IN_PDIFF_CODE: next_input = MSR_IN_PSEUDO_DIFF;
      default: next_input = MSR_IN_DUAL_SE;
    endcase
  end

  // Report code never takes the unused value
  always_comb begin
    if (mode_o.high_precision) begin
      current_mode_field = `MSR_CUR_PRECISION;
    end else if (mode_o.autonomous) begin
      current_mode_field = `MSR_CUR_AUTONOMOUS;
    end else begin
      current_mode_field = `MSR_CUR_MANUAL;
    end
  end

  // Pulses, busy and read data; write-only spots read zero
  always_comb begin
    next_cal = hit_cal && req_i.wdata[`MSR_TRIG_BIT];
    next_launch = hit_start && req_i.wdata[`MSR_LAUNCH_BIT];
    // Launch wins over a done in the same cycle
    next_busy = next_launch || (busy_o && !seq_done_i);
    next_rd_data = rd_data_o;
    if (req_i.rd) begin
      next_rd_data = `MSR_BYTE_ZERO;
      case (req_i.addr)
        `MSR_ADDR_STATUS: begin
          next_rd_data[`MSR_CUR_W-1:0] = current_mode_field;
          next_rd_data[`MSR_FAST_BIT] = fast_link_i;
        end
        `MSR_ADDR_MODE: next_rd_data[`MSR_MODE_W-1:0] = mode_select_field;
        `MSR_ADDR_CHEN: next_rd_data[`MSR_CHAN_N-1:0] = scan_sel_o;
        `MSR_ADDR_INCFG: next_rd_data[`MSR_INCFG_W-1:0] = input_arrangement;
        default: next_rd_data = `MSR_BYTE_ZERO;
      endcase
    end
  end

  // Control state registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cal_pulse_o <= 1'b0;
      scan_launch_o <= 1'b0;
      busy_o <= 1'b0;
      rd_data_o <= `MSR_BYTE_ZERO;
      mode_o <= '{manual: 1'b1, default: 1'b0};
      input_arr_o <= MSR_IN_DUAL_SE;
    end else if (ce_i) begin
      cal_pulse_o <= next_cal;
      scan_launch_o <= next_launch;
      busy_o <= next_busy;
      rd_data_o <= next_rd_data;
      mode_o <= next_mode;
      input_arr_o <= next_input;
    end
  end

  // Checks of the register behaviour
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Pulse may only outlive one cycle when frozen or written again
  chk_cal_launch: assert property (
    ce_i && hit_cal && req_i.wdata[`MSR_TRIG_BIT] |=> cal_pulse_o ##1
      (!$past(ce_i) || !cal_pulse_o || $past(next_cal)))
    else $error("calibration pulse missing or held");
  chk_mode_upper: assert property (
    ce_i && req_i.rd && req_i.addr == `MSR_ADDR_MODE |=> rd_data_o[7:3] == 5'h0)
    else $error("mode register upper bits not zero");
  chk_mode_auto: assert property (
    ce_i && hit_mode && req_i.wdata[2:0] == 3'h6 |=> ##1
      (!$past(ce_i) || mode_o.autonomous && mode_o.auto_seq))
    else $error("autonomous mode not decoded");
  chk_status_ro: assert property (
    ce_i && req_i.wr && req_i.addr == `MSR_ADDR_STATUS && !hit_mode |=>
      $stable(mode_select_field))
    else $error("status write changed mode");
  chk_fast_bit: assert property (
    ce_i && req_i.rd && req_i.addr == `MSR_ADDR_STATUS |=>
      rd_data_o[2] == $past(fast_link_i))
    else $error("fast link bit wrong");
  chk_mode_report: assert property (
    ce_i && req_i.rd && req_i.addr == `MSR_ADDR_STATUS |=>
      rd_data_o[`MSR_CUR_W-1:0] != `MSR_CUR_UNUSED &&
      rd_data_o[7:3] == 5'h0)
    else $error("unused mode code reported");
  chk_input_pdiff: assert property (
    ce_i && hit_incfg && req_i.wdata[1:0] == 2'h2 |=> ##1
      (!$past(ce_i) || input_arr_o == MSR_IN_PSEUDO_DIFF))
    else $error("pseudo-differential not decoded");
  chk_scan_second: assert property (
    ce_i && hit_chen |=> scan_sel_o[1] == $past(req_i.wdata[1]))
    else $error("second channel enable wrong");
  chk_scan_first: assert property (
    ce_i && hit_chen |=> scan_sel_o[0] == $past(req_i.wdata[0]))
    else $error("first channel enable wrong");
  chk_chen_reset: assert property (
    $past(rst_i) |-> scan_sel_o == 2'h3)
    else $error("channel enable reset value wrong");
  chk_scan_busy: assert property (
    ce_i && hit_start && req_i.wdata[0] |=> scan_launch_o && busy_o)
    else $error("scan launch or busy missing");
  chk_wo_zero: assert property (
    ce_i && req_i.rd && (req_i.addr == `MSR_ADDR_CAL ||
      req_i.addr == `MSR_ADDR_START) |=> rd_data_o == 8'h00)
    else $error("write-only location read non-zero");

  cov_scan_done: cover property (scan_launch_o ##[1:20] seq_done_i);
  cov_precision: cover property (mode_o.high_precision);
  cov_cal: cover property (cal_pulse_o);
  cov_frozen_write: cover property (!ce_i && hit_mode);

endmodule : msr_regs
